// [common/tec_cfg.svh]
// Constants of the four-channel 16-bit timer/event counter.
// Assumes inclusion by bare name from the package and the design files.
`ifndef TEC_CFG_SVH
`define TEC_CFG_SVH
`define TEC_NUM_CH 4
`define TEC_NUM_PIN 4
`define TEC_NUM_CLK 8
`define TEC_PRE_W 7
`define TEC_CNT_W 16
`define TEC_CNT_MAX 16'hffff
`define TEC_CNT_RD_STOP 16'h0000
`define TEC_ADDR_W 9
`define TEC_CH_MSB 8
`define TEC_CH_LSB 6
`define TEC_REG_MSB 5
`define TEC_REG_LSB 2
`define TEC_REG_CTL0 4'h0
`define TEC_REG_CTL1 4'h1
`define TEC_REG_IOC0 4'h2
`define TEC_REG_IOC1 4'h3
`define TEC_REG_IOC2 4'h4
`define TEC_REG_OPT0 4'h5
`define TEC_REG_COMPARE_BUFFER_0 4'h6
`define TEC_REG_COMPARE_BUFFER_1 4'h7
`define TEC_REG_CNT 4'h8
`define TEC_CTL0_CE 7
`define TEC_CKS_LSB 0
`define TEC_MD_LSB 0
`define TEC_CTL1_EEE 5
`define TEC_CTL1_EST 6
`define TEC_INV_LSB 2
`define TEC_ESB_LSB 2
`define TEC_ES_RISE 0
`define TEC_ES_FALL 1
`define TEC_MD_INTERVAL 3'h0
`define TEC_MD_EXTTRIG 3'h1
`define TEC_MD_ONESHOT 3'h2
`define TEC_MD_FREERUN 3'h5
`define TEC_IN_MASK 4'h5
`define TEC_TRIG_MASK 4'hd
`define TEC_OUT_MASK 8'ha3
`endif

// [common/tec_pkg.sv]
// Types shared by the timer/event counter design files.
// Assumes the constants header is on the include path.
`include "tec_cfg.svh"
package tec_pkg;
   typedef logic [`TEC_CNT_W-1:0] tec_cnt_t;

   typedef struct packed {
      logic ce;
      logic [2:0] cks;
      logic [2:0] md;
      logic eee;
      logic [3:0] ioc0;
      logic [3:0] ioc1;
      logic [1:0] ioc2;
      logic [1:0] opt0;
      tec_cnt_t compare_buffer_0;
      tec_cnt_t compare_buffer_1;
      tec_cnt_t buf0;
      tec_cnt_t buf1;
      tec_cnt_t cnt;
      logic run;
      logic [1:0] tog;
      logic [1:0] pin;
      logic irq0;
      logic irq1;
      logic ovf;
   } tec_ch_t;

   typedef struct packed {
      tec_ch_t [`TEC_NUM_CH-1:0] ch;
      logic [`TEC_PRE_W-1:0] pre;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } tec_top_t;

   typedef struct packed {
      logic [`TEC_NUM_PIN-1:0] s1;
      logic [`TEC_NUM_PIN-1:0] s2;
      logic [`TEC_NUM_PIN-1:0] s3;
   } tec_sync_t;
endpackage : tec_pkg

// [common/tec_edge_if.sv]
// Edge pulses from the pin edge detector to the timer core.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`include "tec_cfg.svh"
interface tec_edge_if #(parameter int NP = `TEC_NUM_PIN);
   logic [NP-1:0] rise;
   logic [NP-1:0] fall;
   modport det (output rise, output fall);
   modport user (input rise, input fall);
endinterface : tec_edge_if

// [hdl/tec_edge_det.sv]
// Synchroniser and edge detector for the timer input pins.
// Assumes asynchronous pins and an already synchronised reset.
`timescale 1ns/1ps
`include "tec_cfg.svh"
module tec_edge_det
   import tec_pkg::*;
#(
   parameter int NP = `TEC_NUM_PIN
) (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst_n,
   // Raw pins.
   input wire logic [NP-1:0] pin,
   // Edge pulses.
   tec_edge_if.det edges
);
   if (NP != `TEC_NUM_PIN) begin : g_chk
      $error("tec_edge_det: pin count must match the state type");
   end

   tec_sync_t st;
   tec_sync_t next_st;

   always_comb begin
      next_st = st;
      next_st.s1 = pin;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Only the second and third stages are compared, never the first.
   for (genvar i = 0; i < NP; i++) begin : g_edge
      assign edges.rise[i] = st.s2[i] & ~st.s3[i];
      assign edges.fall[i] = ~st.s2[i] & st.s3[i];
   end
endmodule : tec_edge_det

// [hdl/tec_top.sv]
// Four-channel 16-bit timer/event counter with an APB register slave.
// Assumes an APB master on ref_clk and asynchronous timer input pins.
`timescale 1ns/1ps
`include "tec_cfg.svh"
module tec_top
   import tec_pkg::*;
(
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic resetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`TEC_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Timer input pins.
   input wire logic timer_input_a_ch0,
   input wire logic timer_input_b_ch0,
   input wire logic timer_input_a_ch2,
   input wire logic timer_input_b_ch2,
   // Timer output pins.
   output logic timer_output_a_ch0,
   output logic timer_output_b_ch0,
   output logic timer_output_ch2,
   output logic timer_output_ch3,
   // Interrupt requests, one bit per channel.
   output logic [`TEC_NUM_CH-1:0] match_irq_0,
   output logic [`TEC_NUM_CH-1:0] match_irq_1,
   output logic [`TEC_NUM_CH-1:0] ovf_irq
);
   localparam logic [`TEC_NUM_CH-1:0] IN_MASK = `TEC_IN_MASK;
   localparam logic [`TEC_NUM_CH-1:0] TRIG_MASK = `TEC_TRIG_MASK;
   localparam logic [2*`TEC_NUM_CH-1:0] OUT_MASK = `TEC_OUT_MASK;
   localparam logic [2:0] NUM_CH = 3'h4;

   tec_top_t st;
   tec_top_t next_st;
   logic [1:0] rst_sync;
   logic rst_n;
   logic [`TEC_NUM_PIN-1:0] pin_raw;

   tec_edge_if #(.NP(`TEC_NUM_PIN)) edges ();

   // The release edge is aligned to ref_clk so that no flop sees it late.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   assign pin_raw = {timer_input_b_ch2, timer_input_a_ch2,
                     timer_input_b_ch0, timer_input_a_ch0};

   tec_edge_det #(.NP(`TEC_NUM_PIN)) u_edge (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .pin(pin_raw),
      .edges(edges)
   );

   function automatic logic edge_hit(input logic [1:0] sel,
                                     input logic r,
                                     input logic f);
      edge_hit = (sel[`TEC_ES_RISE] & r) | (sel[`TEC_ES_FALL] & f);
   endfunction : edge_hit

   always_comb begin
      logic [`TEC_NUM_CLK-1:0] tick;
      logic acc;
      logic wr;
      logic sw_trig;
      logic hit_a;
      logic hit_b;
      logic evt;
      logic cap0;
      logic cap1;
      logic oneshot;
      logic trig_ok;
      logic trig;
      logic cnt_tick;
      logic upd;
      logic restart;
      logic [2:0] ch_i;
      logic [3:0] reg_i;
      logic [31:0] rd;
      tec_cnt_t ncnt;
      int pa;
      tick = '0;
      sw_trig = 1'b0;
      hit_a = 1'b0;
      hit_b = 1'b0;
      evt = 1'b0;
      cap0 = 1'b0;
      cap1 = 1'b0;
      oneshot = 1'b0;
      trig_ok = 1'b0;
      trig = 1'b0;
      cnt_tick = 1'b0;
      upd = 1'b0;
      restart = 1'b0;
      ncnt = '0;
      pa = 0;
      rd = '0;
      acc = 1'b0;
      wr = 1'b0;
      ch_i = '0;
      reg_i = '0;
      next_st = st;
      next_st.pre = st.pre + 1'b1;
      // Rate k ticks once every 2**k cycles.
      tick[0] = 1'b1;
      for (int k = 1; k < `TEC_NUM_CLK; k++) begin
         tick[k] = tick[k-1] & st.pre[k-1];
      end

      ch_i = paddr[`TEC_CH_MSB:`TEC_CH_LSB];
      reg_i = paddr[`TEC_REG_MSB:`TEC_REG_LSB];
      acc = psel & penable & st.pready;
      wr = acc & pwrite & (ch_i < NUM_CH);
      // One wait state: the answer is prepared while pready is low.
      next_st.pready = psel & penable & ~st.pready;
      next_st.pslverr = 1'b0;
      next_st.prdata = '0;
      if (next_st.pready) begin
         if (ch_i >= NUM_CH) begin
            next_st.pslverr = 1'b1;
         end else if (!pwrite) begin
            case (reg_i)
               `TEC_REG_CTL0: begin
                  rd[`TEC_CTL0_CE] = st.ch[ch_i[1:0]].ce;
                  rd[`TEC_CKS_LSB +: 3] = st.ch[ch_i[1:0]].cks;
               end
               `TEC_REG_CTL1: begin
                  rd[`TEC_MD_LSB +: 3] = st.ch[ch_i[1:0]].md;
                  rd[`TEC_CTL1_EEE] = st.ch[ch_i[1:0]].eee;
               end
               `TEC_REG_IOC0: rd[3:0] = st.ch[ch_i[1:0]].ioc0;
               `TEC_REG_IOC1: rd[3:0] = st.ch[ch_i[1:0]].ioc1;
               `TEC_REG_IOC2: rd[1:0] = st.ch[ch_i[1:0]].ioc2;
               `TEC_REG_OPT0: rd[1:0] = st.ch[ch_i[1:0]].opt0;
               `TEC_REG_COMPARE_BUFFER_0: rd[15:0] = st.ch[ch_i[1:0]].compare_buffer_0;
               `TEC_REG_COMPARE_BUFFER_1: rd[15:0] = st.ch[ch_i[1:0]].compare_buffer_1;
               `TEC_REG_CNT: begin
                  // A stopped counter reads zero though it holds all ones.
                  rd[15:0] = st.ch[ch_i[1:0]].ce ?
                             st.ch[ch_i[1:0]].cnt :
                             `TEC_CNT_RD_STOP;
               end
               default: begin
                  rd = '0;
               end
            endcase
            next_st.prdata = rd;
         end
      end

      // The hidden buffers have no address; only the registers do.
      if (wr) begin
         case (reg_i)
            `TEC_REG_CTL0: begin
               next_st.ch[ch_i[1:0]].ce = pwdata[`TEC_CTL0_CE];
               next_st.ch[ch_i[1:0]].cks = pwdata[`TEC_CKS_LSB +: 3];
            end
            `TEC_REG_CTL1: begin
               next_st.ch[ch_i[1:0]].md = pwdata[`TEC_MD_LSB +: 3];
               next_st.ch[ch_i[1:0]].eee = pwdata[`TEC_CTL1_EEE];
            end
            `TEC_REG_IOC0: next_st.ch[ch_i[1:0]].ioc0 = pwdata[3:0];
            `TEC_REG_IOC1: next_st.ch[ch_i[1:0]].ioc1 = pwdata[3:0];
            `TEC_REG_IOC2: next_st.ch[ch_i[1:0]].ioc2 = pwdata[1:0];
            `TEC_REG_OPT0: next_st.ch[ch_i[1:0]].opt0 = pwdata[1:0];
            `TEC_REG_COMPARE_BUFFER_0: next_st.ch[ch_i[1:0]].compare_buffer_0 = pwdata[15:0];
            `TEC_REG_COMPARE_BUFFER_1: next_st.ch[ch_i[1:0]].compare_buffer_1 = pwdata[15:0];
            default: begin
               next_st.ch[ch_i[1:0]].cnt = st.ch[ch_i[1:0]].cnt;
            end
         endcase
      end

      for (int c = 0; c < `TEC_NUM_CH; c++) begin
         pa = c & 2;
         hit_a = IN_MASK[c] & edge_hit(st.ch[c].ioc1[1:0],
                 edges.rise[pa], edges.fall[pa]);
         hit_b = IN_MASK[c] &
                 edge_hit(st.ch[c].ioc1[`TEC_ESB_LSB +: 2],
                 edges.rise[pa+1], edges.fall[pa+1]);
         evt = IN_MASK[c] & edge_hit(st.ch[c].ioc2,
               edges.rise[pa], edges.fall[pa]);
         // The first pin counts events, else triggers and captures independently.
         cap0 = IN_MASK[c] & st.ch[c].opt0[0] & ~st.ch[c].eee;
         cap1 = IN_MASK[c] & st.ch[c].opt0[1];
         oneshot = st.ch[c].md == `TEC_MD_ONESHOT;
         trig_ok = TRIG_MASK[c] &
                   (oneshot | (st.ch[c].md == `TEC_MD_EXTTRIG));
         sw_trig = wr & (ch_i[1:0] == c[1:0]) &
                   (reg_i == `TEC_REG_CTL1) & pwdata[`TEC_CTL1_EST];
         // Channel 3 has no input pin, so evt is zero there.
         trig = trig_ok & (sw_trig | (evt & ~st.ch[c].eee));
         cnt_tick = (IN_MASK[c] & st.ch[c].eee) ? evt :
                    tick[st.ch[c].cks];
         upd = 1'b0;
         restart = 1'b0;
         ncnt = st.ch[c].cnt;
         next_st.ch[c].irq0 = 1'b0;
         next_st.ch[c].irq1 = 1'b0;
         next_st.ch[c].ovf = 1'b0;
         if (!st.ch[c].ce) begin
            ncnt = `TEC_CNT_MAX;
            next_st.ch[c].run = 1'b0;
            next_st.ch[c].tog = 2'h0;
            next_st.ch[c].buf0 = st.ch[c].compare_buffer_0;
            next_st.ch[c].buf1 = st.ch[c].compare_buffer_1;
         end else if (trig & ~(oneshot & st.ch[c].run)) begin
            ncnt = '0;
            upd = 1'b1;
            restart = 1'b1;
            next_st.ch[c].run = 1'b1;
         end else if (cnt_tick & (st.ch[c].run | ~trig_ok)) begin
            upd = 1'b1;
            if (!st.ch[c].run) begin
               ncnt = '0;
               restart = 1'b1;
               next_st.ch[c].run = 1'b1;
            end else if (st.ch[c].md != `TEC_MD_FREERUN && !cap0 &&
                         st.ch[c].cnt == st.ch[c].buf0) begin
               ncnt = '0;
               restart = 1'b1;
               if (oneshot) begin
                  ncnt = `TEC_CNT_MAX;
                  upd = 1'b0;
                  restart = 1'b0;
                  next_st.ch[c].run = 1'b0;
               end
            end else begin
               ncnt = st.ch[c].cnt + 1'b1;
               next_st.ch[c].ovf = st.ch[c].cnt == `TEC_CNT_MAX;
               restart = next_st.ch[c].ovf;
            end
         end
         // Buffers reload at a restart and while the channel is stopped, so a cycle never sees a mix.
         if (restart) begin
            next_st.ch[c].buf0 = st.ch[c].compare_buffer_0;
            next_st.ch[c].buf1 = st.ch[c].compare_buffer_1;
         end
         next_st.ch[c].cnt = ncnt;
         if (upd & ~cap0 & (ncnt == next_st.ch[c].buf0)) begin
            next_st.ch[c].irq0 = 1'b1;
         end
         if (upd & ~cap1 & (ncnt == next_st.ch[c].buf1)) begin
            next_st.ch[c].irq1 = 1'b1;
         end
         // A capture edge beats a software write in the same cycle.
         if (cap0 & hit_a) begin
            next_st.ch[c].compare_buffer_0 = st.ch[c].cnt;
            next_st.ch[c].irq0 = 1'b1;
         end
         if (cap1 & hit_b) begin
            next_st.ch[c].compare_buffer_1 = st.ch[c].cnt;
            next_st.ch[c].irq1 = 1'b1;
         end
         if (st.ch[c].ce) begin
            next_st.ch[c].tog = st.ch[c].tog ^
               {next_st.ch[c].irq1, next_st.ch[c].irq0};
         end
         for (int k = 0; k < 2; k++) begin
            next_st.ch[c].pin[k] = OUT_MASK[2*c+k] &
               st.ch[c].ioc0[k] &
               (next_st.ch[c].tog[k] ^ st.ch[c].ioc0[`TEC_INV_LSB+k]);
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign prdata = st.prdata;
   assign pready = st.pready;
   assign pslverr = st.pslverr;
   assign timer_output_a_ch0 = st.ch[0].pin[0];
   assign timer_output_b_ch0 = st.ch[0].pin[1];
   assign timer_output_ch2 = st.ch[2].pin[1];
   assign timer_output_ch3 = st.ch[3].pin[1];

   for (genvar c = 0; c < `TEC_NUM_CH; c++) begin : g_irq
      assign match_irq_0[c] = st.ch[c].irq0;
      assign match_irq_1[c] = st.ch[c].irq1;
      assign ovf_irq[c] = st.ch[c].ovf;
   end

   AST_STOP_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !st.ch[0].ce ##1 !st.ch[0].ce |-> st.ch[0].cnt == `TEC_CNT_MAX)
      else $error("stopped counter not at all ones");

   AST_RD_STOP: assert property (@(posedge ref_clk) disable iff (!rst_n)
      psel && penable && !pready && !pwrite &&
      paddr[`TEC_REG_MSB:`TEC_REG_LSB] == `TEC_REG_CNT &&
      paddr[`TEC_CH_MSB:`TEC_CH_LSB] == 3'h1 && !st.ch[1].ce
      |=> pready && prdata == 32'h0)
      else $error("stopped counter did not read zero");

   AST_RESET_STOP: assert property (@(posedge ref_clk)
      $rose(rst_n) |-> st.ch == '0)
      else $error("channel state not cleared by reset");

   AST_MATCH0: assert property (@(posedge ref_clk) disable iff (!rst_n)
      st.ch[1].irq0 |-> st.ch[1].cnt == st.ch[1].buf0 ##1 !st.ch[1].irq0
      || st.ch[1].cnt == st.ch[1].buf0)
      else $error("match 0 without equal count");

   AST_MATCH1: assert property (@(posedge ref_clk) disable iff (!rst_n)
      st.ch[3].irq1 |-> st.ch[3].cnt == st.ch[3].buf1)
      else $error("match 1 without equal count");

   AST_BUF_LOAD: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !st.ch[2].ce ##1 !st.ch[2].ce ##1 !st.ch[2].ce
      |-> st.ch[2].buf0 == $past(st.ch[2].compare_buffer_0))
      else $error("compare buffer 0 not loaded");

   AST_NO_CAPTURE: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !(psel && penable && pready && pwrite)
      |=> $stable(st.ch[3].compare_buffer_0) && $stable(st.ch[3].compare_buffer_1))
      else $error("compare-only channel register changed by itself");

   AST_OVF: assert property (@(posedge ref_clk) disable iff (!rst_n)
      st.ch[2].ovf |-> st.ch[2].cnt == '0 &&
      $past(st.ch[2].cnt) == `TEC_CNT_MAX)
      else $error("overflow without wrap");

   AST_OUT_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !st.ch[2].ioc0[1] |=> !timer_output_ch2)
      else $error("disabled output driven high");

   AST_CNT_STEP: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $past(st.ch[1].run) && st.ch[1].run &&
      st.ch[1].cnt != $past(st.ch[1].cnt)
      |-> st.ch[1].cnt == tec_cnt_t'($past(st.ch[1].cnt) + 1'b1) ||
      st.ch[1].cnt == '0)
      else $error("counter moved by other than one");
endmodule : tec_top

// [testbench/tec_pin_model.sv]
// Model of the pin side: drives the four timer input pins.
// Assumes the bench calls pulse right after a rising edge of ref_clk.
`timescale 1ns/1ps
module tec_pin_model (
   // Clock.
   input wire logic ref_clk,
   // Pins towards the timer, a and b of channel 0, then of channel 2.
   output logic [3:0] pin
);
   initial begin
      pin = 4'h0;
   end

   // Each level is held five cycles, longer than the two-flop synchroniser,
   // so no edge can be lost between samples.
   task automatic pulse(input int idx, input int n);
      repeat (n) begin
         pin[idx] <= 1'b1;
         repeat (5) @(posedge ref_clk);
         pin[idx] <= 1'b0;
         repeat (5) @(posedge ref_clk);
      end
   endtask : pulse
endmodule : tec_pin_model

// [testbench/tb_tec_top.sv]
// Self-checking bench for the timer/event counter top module.
// Assumes the constants header is on the include path.
`timescale 1ns/1ps
`include "tec_cfg.svh"
module tb_tec_top;
   logic ref_clk, resetn, psel, penable, pwrite, pready, pslverr;
   logic [`TEC_ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pins;
   logic out_a0, out_b0, out_2, out_3;
   logic [`TEC_NUM_CH-1:0] m0, m1, ov;
   int miscompares, compares, seed;
   int regs[4] = '{0, 1, 6, 7};

   tec_top tec_top_inst (.ref_clk(ref_clk), .resetn(resetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timer_input_a_ch0(pins[0]), .timer_input_b_ch0(pins[1]),
      .timer_input_a_ch2(pins[2]), .timer_input_b_ch2(pins[3]),
      .timer_output_a_ch0(out_a0), .timer_output_b_ch0(out_b0),
      .timer_output_ch2(out_2), .timer_output_ch3(out_3),
      .match_irq_0(m0), .match_irq_1(m1), .ovf_irq(ov));

   tec_pin_model tec_pin_model_inst (.ref_clk(ref_clk), .pin(pins));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   task tally_and_finish;
      $display("miscompares %0d compares %0d", miscompares, compares);
      if (miscompares == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : tally_and_finish

   task check(input logic [31:0] seen, input logic [31:0] exp,
              input string msg);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: %s seen %h expected %h",
                  $time, msg, seen, exp);
      end
   endtask : check

   task timeout(input string msg);
      miscompares++;
      $display("wrong value at %0t: no answer for %s", $time, msg);
      tally_and_finish();
   endtask : timeout

   // Tasks are entered right after a rising edge and leave one edge after
   // the release, so no signal is assigned twice in one time step.
   task apb(input logic wr, input int ch, input int idx,
            input logic [31:0] wd, output logic [31:0] rd,
            output logic err);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {3'(ch), 4'(idx), 2'b00};
      pwdata <= wd;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) timeout("bus access");
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask : apb

   task reg_wr(input int ch, input int idx, input logic [31:0] v);
      logic [31:0] d;
      logic e;
      apb(1'b1, ch, idx, v, d, e);
   endtask : reg_wr

   function logic pick(input int kind, input int ch);
      case (kind)
         0: return m0[ch];
         1: return m1[ch];
         default: return ov[ch];
      endcase
   endfunction : pick

   task wait_irq(input int kind, input int ch, input int bound,
                 output int n);
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pick(kind, ch) !== 1'b1 && n < bound);
      if (pick(kind, ch) !== 1'b1) timeout("request pulse");
   endtask : wait_irq

   task count_pulses(input int kind, input int ch, input int cycles,
                     output int c);
      c = 0;
      repeat (cycles) begin
         @(posedge ref_clk);
         if (pick(kind, ch) === 1'b1) c++;
      end
   endtask : count_pulses

   // Ticks of count x+1 at a prescale of 2 to the power k.
   function int exp_gap(input int x, input int k);
      return (x + 1) << k;
   endfunction : exp_gap

   // Matches expected when the counter compares at 3, i.e. every 4 events.
   function int exp_events(input int e, input int p);
      return ((e & 1) + ((e >> 1) & 1)) * p / 4;
   endfunction : exp_events

   initial begin
      int n, c, nn, mm;
      logic [31:0] d;
      logic [31:0] d2;
      logic err;
      logic [15:0] v;
      seed = 32'hcf57;
      resetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = 32'h0;
      repeat (12) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge ref_clk);
      check({28'h0, out_a0, out_b0, out_2, out_3}, 32'h0, "pins");
      for (int ch = 0; ch < 4; ch++) begin
         foreach (regs[i]) begin
            apb(1'b0, ch, regs[i], 32'h0, d, err);
            check(d, 32'h0, "reset value");
         end
         apb(1'b0, ch, 8, 32'h0, d, err);
         check(d, 32'h0, "stopped count");
         v = 16'($random(seed));
         reg_wr(ch, 6, {16'h0, v});
         apb(1'b0, ch, 6, 32'h0, d, err);
         check(d, {16'h0, v}, "compare reg 0");
         v = 16'($random(seed));
         reg_wr(ch, 7, {16'h0, v});
         apb(1'b0, ch, 7, 32'h0, d, err);
         check(d, {16'h0, v}, "compare reg 1");
      end
      reg_wr(5, 6, 32'hffffffff);
      apb(1'b0, 5, 6, 32'h0, d, err);
      check({31'h0, err}, 32'h1, "unmapped error");
      check(d, 32'h0, "unmapped data");
      // Interval timing on a channel without pins, clock rates 0, 2, 4 and 6.
      for (int k = 0; k < 8; k += 2) begin
         nn = 3 + ($unsigned($random(seed)) % 8);
         mm = $unsigned($random(seed)) % nn;
         reg_wr(1, 0, 32'h0);
         reg_wr(1, 6, 32'(nn));
         reg_wr(1, 7, 32'(mm));
         reg_wr(1, 0, 32'h80 | 32'(k));
         wait_irq(0, 1, 5000, n);
         wait_irq(1, 1, 5000, n);
         check(32'(n), 32'(exp_gap(mm, k)), "match 1 gap");
         wait_irq(0, 1, 5000, n);
         check(32'(n), 32'(exp_gap(nn - mm - 1, k)), "gap");
         wait_irq(0, 1, 5000, n);
         check(32'(n), 32'(exp_gap(nn, k)), "period");
      end
      reg_wr(1, 0, 32'h0);
      // Free-running: overflow comes 16 ticks after a match at fff0.
      reg_wr(2, 1, 32'h5);
      reg_wr(2, 6, 32'hfff0);
      reg_wr(2, 7, 32'h10);
      reg_wr(2, 2, 32'h2);
      reg_wr(2, 0, 32'h80);
      // Two back-to-back reads sample the count four cycles apart.
      apb(1'b0, 2, 8, 32'h0, d, err);
      apb(1'b0, 2, 8, 32'h0, d2, err);
      check(32'(16'(d2 - d)), 32'h4, "live count");
      wait_irq(0, 2, 70000, n);
      wait_irq(2, 2, 100, n);
      check(32'(n), 32'(exp_gap(15, 0)), "overflow");
      check({31'h0, out_2}, 32'h1, "output toggled");
      reg_wr(2, 0, 32'h0);
      // Event counting from the first pin of channels 0 and 2.
      for (int i = 0; i < 2; i++) begin
         for (int e = 0; e < 4; e++) begin
            reg_wr(2 * i, 0, 32'h0);
            reg_wr(2 * i, 1, 32'h20);
            reg_wr(2 * i, 4, 32'(e));
            reg_wr(2 * i, 6, 32'h3);
            reg_wr(2 * i, 0, 32'h80);
            fork
               tec_pin_model_inst.pulse(2 * i, 4);
               count_pulses(0, 2 * i, 90, c);
            join
            check(32'(c), 32'(exp_events(e, 4)), "events");
         end
         reg_wr(2 * i, 0, 32'h0);
      end
      // One-shot on channel 3 waits for the software trigger.
      reg_wr(3, 6, 32'h5);
      reg_wr(3, 1, 32'h2);
      reg_wr(3, 0, 32'h80);
      count_pulses(0, 3, 40, c);
      check(32'(c), 32'h0, "no trigger");
      fork
         reg_wr(3, 1, 32'h42);
         count_pulses(0, 3, 60, c);
      join
      check(32'(c), 32'h1, "one shot");
      apb(1'b0, 3, 1, 32'h0, d, err);
      check(d, 32'h2, "trigger bit reads zero");
      tally_and_finish();
   end
endmodule : tb_tec_top
